// File: rtl/uecc_pkg.sv
// Constants and lookups shared by the endpoint command decoder
// Summary of operation
// - Check-status returns status copy, clears nothing
// - Acknowledge setup acts on both control endpoints
// - Error-code reads return per-endpoint error byte
// - Unlock takes two bytes, gates register writes
// - 16-bit bus moves N bytes in (N+1)/2 words
// - Setup register written 20-2F, read 30-3F
// - Byte holds enable, direction, double, type, size
// - USB bus reset disables every endpoint
// - Allocation starts after in-order configuration completes
// - Memory-affecting change invalidates every endpoint buffer
// - Enable bit allocates memory, zero allocates none
// - Direction bit: 0 OUT/DMA read, 1 IN/DMA write
// - Double-buffer bit selects two alternating buffers
// - Type bit: 1 isochronous, 0 bulk or interrupt
package uecc_pkg;
   localparam int         NUM_EP        = 16;          // Control OUT, control IN, 1..14
   localparam logic [7:0] CMD_CFG_WR    = 8'h20;       // Setup register write base
   localparam logic [7:0] CMD_CFG_RD    = 8'h30;       // Setup register read base
   localparam logic [7:0] CMD_CHK       = 8'hD0;       // Status image read base
   localparam logic [7:0] CMD_ERR       = 8'hA0;       // Error code read base
   localparam logic [7:0] CMD_UNLOCK    = 8'hB0;       // Unlock command
   localparam logic [7:0] CMD_ACK_SETUP = 8'hF4;       // Acknowledge setup
   localparam int         BIT_EN        = 7;           // buffer_enable_bit
   localparam int         BIT_DIR       = 6;           // endpoint_direction_bit
   localparam int         BIT_DBL       = 5;           // double_buffer_flag
   localparam int         BIT_ISO       = 4;           // isochronous_type_bit
   localparam logic [7:0] CFG_RESET     = 8'h00;       // Setup register after reset
   localparam logic [7:0] MEM_MASK      = 8'hAF;       // Bits that move memory
   localparam logic [15:0] UNLOCK_KEY   = 16'hA5A5;    // Arbitrary unlock value
   localparam logic [3:0] UNLOCK_BYTES  = 4'h2;        // Unlock payload length
   localparam int         FIFO_W        = 16;          // Reply word width
   localparam int         FIFO_D        = 8;           // Reply queue depth

   // Words needed for n bytes on the 16-bit bus
   function automatic logic [3:0] words_for(input logic [3:0] n);
      logic [4:0] s;
      s = {1'b0, n} + 5'h01;
      return s[4:1];
   endfunction

   // Maximum packet size for a size code
   function automatic logic [10:0] pkt_size(input logic [3:0] c);
      logic [10:0] t [16];
      t = '{11'h008, 11'h010, 11'h020, 11'h040, 11'h080, 11'h100, 11'h180, 11'h200,
            11'h280, 11'h300, 11'h380, 11'h3FF, 11'h000, 11'h000, 11'h000, 11'h000};
      return t[c];
   endfunction

   // Bytes reserved for one endpoint setup byte
   function automatic logic [15:0] cfg_alloc(input logic [7:0] cfg);
      logic [15:0] s;
      s = {5'h00, pkt_size(cfg[3:0])};
      if (!cfg[BIT_EN]) return 16'h0000;
      return cfg[BIT_DBL] ? {s[14:0], 1'b0} : s;
   endfunction
endpackage

// File: rtl/uecc_top.sv
// Endpoint setup command decoder with its reply queue
`timescale 1ns/1ps

// Reply queue: flip-flop storage, valid and ready on both sides
module uecc_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0]      mem_q [D];             // Storage words
   logic [AW-1:0]     wr_q;                  // Write index
   logic [AW-1:0]     rd_q;                  // Read index
   logic [AW:0]       cnt_q;                 // Words held
   logic              push;
   logic              pop;

   assign in_ready_o  = (cnt_q != (AW+1)'(D));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rd_q];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // Storage write
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // Indices and fill level
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + AW'(1);
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + AW'(1);
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module uecc_top (
   input  wire logic         mclk_i,
   input  wire logic         resetn_i,
   input  wire logic         bus16_i,
   input  wire logic         cmd_wr_i,
   input  wire logic [7:0]   cmd_code_i,
   output logic              cmd_ready_o,
   input  wire logic         dat_wr_i,
   input  wire logic [15:0]  dat_i,
   input  wire logic         dat_rd_i,
   output logic [15:0]       rd_data_o,
   output logic              rd_valid_o,
   input  wire logic         usb_reset_i,
   input  wire logic [127:0] ep_status_i,
   input  wire logic [127:0] err_code_i,
   input  wire logic [15:0]  pkt_done_i,
   output logic              ack_setup_o,
   output logic              unlocked_o,
   output logic [15:0]       cfg_enable_o,
   output logic [15:0]       cfg_dir_in_o,
   output logic [15:0]       cfg_dbl_o,
   output logic [15:0]       cfg_iso_o,
   output logic [15:0]       buf_sel_o,
   output logic              alloc_done_o,
   output logic [15:0]       alloc_bytes_o,
   output logic              fifo_invalidate_o
);
   typedef enum logic [1:0] {ST_IDLE, ST_CFG_DATA, ST_UNLOCK_DATA, ST_UNLOCK_CHK} uecc_st_t;

   logic         rst_s1_q;                   // Reset sync first stage
   logic         rst_n;                      // Released reset copy
   uecc_st_t     st_q;                       // Command state
   logic         ready_q;                    // Command accept
   logic [3:0]   ep_q;                       // Endpoint under write
   logic [3:0]   rem_q;                      // Unlock transfers left
   logic [15:0]  key_q;                      // Unlock payload
   logic         unlocked_q;                 // Write access open
   logic [7:0]   cfg_q [uecc_pkg::NUM_EP];   // endpoint_setup_register array
   logic         pend_q;                     // Reply waiting for queue
   logic [15:0]  reply_q;                    // Reply word
   logic         ack_q;                      // Setup acknowledge pulse
   logic [4:0]   seq_q;                      // In-order setup progress
   logic         go_q;                       // Allocation start pulse
   logic         done_q;                     // Allocation complete
   logic [15:0]  bytes_q;                    // Bytes allocated
   logic         inval_q;                    // Buffer invalidate pulse
   logic [15:0]  sel_q;                      // Alternating buffer select
   logic         rdv_q;                      // Output word valid
   logic [15:0]  rdd_q;                      // Output word
   logic         take;                       // Command taken
   logic [3:0]   idx;                        // Endpoint from code
   logic [7:0]   reply_sel;                  // Byte chosen for reply
   logic         is_read;                    // Code expects one byte back
   logic         wr_cfg;                     // Setup byte arriving
   logic         wr_ok;                      // Setup byte accepted
   logic         mem_chg;                    // Write moves memory
   logic [15:0]  alloc_sum;                  // Live allocation total
   logic         f_ready;
   logic         f_ov;
   logic [15:0]  f_od;
   logic         f_pop;
   logic         any_en;

   // Group compare on the upper nibble
   function automatic logic in_grp(input logic [7:0] c, input logic [7:0] base);
      return c[7:4] == base[7:4];
   endfunction

   // Reset release through two flops
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   assign take    = cmd_wr_i && ready_q;
   assign idx     = cmd_code_i[3:0];
   assign is_read = in_grp(cmd_code_i, uecc_pkg::CMD_CFG_RD) ||
                    in_grp(cmd_code_i, uecc_pkg::CMD_CHK) ||
                    in_grp(cmd_code_i, uecc_pkg::CMD_ERR);
   assign wr_cfg  = (st_q == ST_CFG_DATA) && dat_wr_i;
   assign wr_ok   = wr_cfg && unlocked_q;
   assign mem_chg = ((dat_i[7:0] ^ cfg_q[ep_q]) & uecc_pkg::MEM_MASK) != 8'h00;

   // Reply byte selection
   always_comb begin
      reply_sel = 8'h00;
      if (in_grp(cmd_code_i, uecc_pkg::CMD_CFG_RD)) begin
         reply_sel = cfg_q[idx];
      end else if (in_grp(cmd_code_i, uecc_pkg::CMD_CHK)) begin
         reply_sel = ep_status_i[{idx, 3'b000} +: 8];
      end else if (in_grp(cmd_code_i, uecc_pkg::CMD_ERR)) begin
         reply_sel = err_code_i[{idx, 3'b000} +: 8];
      end
   end

   // Allocation total over enabled endpoints
   always_comb begin
      alloc_sum = 16'h0000;
      any_en    = 1'b0;
      for (int i = 0; i < uecc_pkg::NUM_EP; i++) begin
         alloc_sum = alloc_sum + uecc_pkg::cfg_alloc(cfg_q[i]);
         any_en    = any_en | cfg_q[i][uecc_pkg::BIT_EN];
      end
   end

   // Command state and payload collection
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q  <= ST_IDLE;
         ep_q  <= 4'h0;
         rem_q <= 4'h0;
         key_q <= 16'h0000;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (take && in_grp(cmd_code_i, uecc_pkg::CMD_CFG_WR)) begin
                  st_q <= ST_CFG_DATA;
                  ep_q <= idx;
               end else if (take && cmd_code_i == uecc_pkg::CMD_UNLOCK) begin
                  st_q  <= ST_UNLOCK_DATA;
                  // Word count on the wide bus
                  rem_q <= bus16_i ? uecc_pkg::words_for(uecc_pkg::UNLOCK_BYTES)
                                   : uecc_pkg::UNLOCK_BYTES;
               end
            end
            ST_CFG_DATA: begin
               if (dat_wr_i) begin
                  st_q <= ST_IDLE;
               end
            end
            ST_UNLOCK_DATA: begin
               if (dat_wr_i) begin
                  // Low byte first on the narrow bus
                  key_q <= bus16_i ? dat_i : {dat_i[7:0], key_q[15:8]};
                  rem_q <= rem_q - 4'h1;
                  if (rem_q == 4'h1) begin
                     st_q <= ST_UNLOCK_CHK;
                  end
               end
            end
            ST_UNLOCK_CHK: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Command ready drops the cycle after a take
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= !take && (st_q == ST_IDLE) && !pend_q;
      end
   end

   // Write access follows the unlock payload
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         unlocked_q <= 1'b1;
      end else if (st_q == ST_UNLOCK_CHK) begin
         unlocked_q <= (key_q == uecc_pkg::UNLOCK_KEY);
      end
   end

   // One-byte replies, upper byte zero
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         pend_q  <= 1'b0;
         reply_q <= 16'h0000;
      end else if (take && is_read) begin
         pend_q  <= 1'b1;
         reply_q <= {8'h00, reply_sel};
      end else if (pend_q && f_ready) begin
         pend_q  <= 1'b0;
      end
   end

   // Acknowledge setup pulse for both control endpoints
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= take && (cmd_code_i == uecc_pkg::CMD_ACK_SETUP);
      end
   end

   // Setup registers and bus reset disable
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < uecc_pkg::NUM_EP; i++) begin
            cfg_q[i] <= uecc_pkg::CFG_RESET;
         end
      end else if (usb_reset_i) begin
         for (int i = 0; i < uecc_pkg::NUM_EP; i++) begin
            cfg_q[i][uecc_pkg::BIT_EN] <= 1'b0;
         end
      end else if (wr_ok) begin
         cfg_q[ep_q] <= dat_i[7:0];
      end
   end

   // In-order setup tracking and allocation
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         seq_q   <= 5'h00;
         go_q    <= 1'b0;
         done_q  <= 1'b0;
         bytes_q <= 16'h0000;
      end else begin
         go_q <= 1'b0;
         if (go_q) begin
            done_q  <= 1'b1;
            bytes_q <= alloc_sum;
         end
         if (usb_reset_i) begin
            seq_q  <= 5'h00;
            done_q <= 1'b0;
         end else if (wr_ok) begin
            if ({1'b0, ep_q} == seq_q) begin
               seq_q <= seq_q + 5'h01;
               // Last endpoint closes the sequence
               go_q  <= (ep_q == 4'hF);
            end else begin
               // Out of order: restart, counting endpoint 0
               seq_q <= (ep_q == 4'h0) ? 5'h01 : 5'h00;
            end
            if (mem_chg) begin
               done_q <= 1'b0;
            end
         end
      end
   end

   // Invalidate all buffers when memory moves
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         inval_q <= 1'b0;
      end else begin
         inval_q <= (wr_ok && mem_chg) || (usb_reset_i && any_en);
      end
   end

   // Alternating buffer select per endpoint
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         sel_q <= 16'h0000;
      end else begin
         for (int i = 0; i < uecc_pkg::NUM_EP; i++) begin
            if (!cfg_q[i][uecc_pkg::BIT_DBL]) begin
               sel_q[i] <= 1'b0;
            end else if (pkt_done_i[i]) begin
               sel_q[i] <= ~sel_q[i];
            end
         end
      end
   end

   uecc_fifo #(
      .W (uecc_pkg::FIFO_W),
      .D (uecc_pkg::FIFO_D)
   ) u_fifo (
      .clk_i       (mclk_i),
      .rst_n_i     (rst_n),
      .in_valid_i  (pend_q),
      .in_ready_o  (f_ready),
      .in_data_i   (reply_q),
      .out_valid_o (f_ov),
      .out_ready_i (f_pop),
      .out_data_o  (f_od)
   );

   assign f_pop = !rdv_q || dat_rd_i;

   // Output word register
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdv_q <= 1'b0;
         rdd_q <= 16'h0000;
      end else if (f_pop) begin
         rdv_q <= f_ov;
         rdd_q <= f_od;
      end
   end

   // Per-endpoint setup fields
   for (genvar g = 0; g < uecc_pkg::NUM_EP; g++) begin : g_ep
      assign cfg_enable_o[g] = cfg_q[g][uecc_pkg::BIT_EN];
      assign cfg_dir_in_o[g] = cfg_q[g][uecc_pkg::BIT_DIR];
      assign cfg_dbl_o[g]    = cfg_q[g][uecc_pkg::BIT_DBL];
      assign cfg_iso_o[g]    = cfg_q[g][uecc_pkg::BIT_ISO];
   end

   assign cmd_ready_o       = ready_q;
   assign rd_data_o         = rdd_q;
   assign rd_valid_o        = rdv_q;
   assign ack_setup_o       = ack_q;
   assign unlocked_o        = unlocked_q;
   assign buf_sel_o         = sel_q;
   assign alloc_done_o      = done_q;
   assign alloc_bytes_o     = bytes_q;
   assign fifo_invalidate_o = inval_q;

   // Checks on the decoder
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n);

   property p_chk_copy;
      take && in_grp(cmd_code_i, uecc_pkg::CMD_CHK) |=>
         reply_q == {8'h00, $past(ep_status_i[{cmd_code_i[3:0], 3'b000} +: 8])} &&
         !inval_q && pend_q;
   endproperty
   a_chk_copy: assert property (p_chk_copy) else $error("status copy wrong");

   property p_ack;
      take && cmd_code_i == uecc_pkg::CMD_ACK_SETUP |=> ack_q ##1 !ack_q;
   endproperty
   a_ack: assert property (p_ack) else $error("setup ack not one pulse");

   property p_err;
      take && in_grp(cmd_code_i, uecc_pkg::CMD_ERR) |=>
         reply_q == {8'h00, $past(err_code_i[{cmd_code_i[3:0], 3'b000} +: 8])};
   endproperty
   a_err: assert property (p_err) else $error("error code reply wrong");

   property p_locked;
      wr_cfg && !unlocked_q |=> cfg_q[$past(ep_q)] == $past(cfg_q[ep_q]);
   endproperty
   a_locked: assert property (p_locked) else $error("locked write landed");

   property p_words;
      take && cmd_code_i == uecc_pkg::CMD_UNLOCK |=>
         st_q == ST_UNLOCK_DATA && rem_q == ($past(bus16_i) ? 4'h1 : 4'h2);
   endproperty
   a_words: assert property (p_words) else $error("unlock transfer count wrong");

   property p_bus_reset;
      usb_reset_i |=> cfg_enable_o == 16'h0000 && !done_q;
   endproperty
   a_bus_reset: assert property (p_bus_reset) else $error("bus reset left enabled");

   property p_alloc;
      go_q |=> done_q && bytes_q == $past(alloc_sum);
   endproperty
   a_alloc: assert property (p_alloc) else $error("allocation not taken");

   property p_inval;
      wr_ok && mem_chg && !usb_reset_i |=> inval_q && !done_q;
   endproperty
   a_inval: assert property (p_inval) else $error("no invalidate on change");

   property p_dbl;
      pkt_done_i[2] && cfg_q[2][uecc_pkg::BIT_DBL] && !usb_reset_i && !wr_ok |=>
         sel_q[2] != $past(sel_q[2]);
   endproperty
   a_dbl: assert property (p_dbl) else $error("buffer did not alternate");

   c_alloc: cover property (go_q ##1 done_q);
   c_unlock: cover property (st_q == ST_UNLOCK_CHK ##1 unlocked_q);
   c_reply: cover property (rdv_q && dat_rd_i);
   c_full: cover property (pend_q && !f_ready);
endmodule

// File: test/uecc_host.sv
// Host model driving the command port and popping replies
`timescale 1ns/1ps
module uecc_host (
   input  wire logic        clk_i,
   input  wire logic        cmd_ready_i,
   input  wire logic [15:0] rd_data_i,
   input  wire logic        rd_valid_i,
   output logic             cmd_wr_o,
   output logic [7:0]       cmd_code_o,
   output logic             dat_wr_o,
   output logic [15:0]      dat_o,
   output logic             dat_rd_o
);
   // Idle levels at time zero
   initial begin
      cmd_wr_o   = 1'b0;
      cmd_code_o = 8'h00;
      dat_wr_o   = 1'b0;
      dat_o      = 16'h0000;
      dat_rd_o   = 1'b0;
   end

   // Command held until sampled with ready; no validate or clear codes
   task automatic cmd(input logic [7:0] c, output bit ok);
      int n;
      n = 0;
      cmd_code_o <= c;
      cmd_wr_o   <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (cmd_ready_i !== 1'b1 && n < 40); // Generous wait for slow commands
      ok = (cmd_ready_i === 1'b1);
      cmd_wr_o   <= 1'b0;
      cmd_code_o <= ~c;
      @(posedge clk_i);                      // Release is seen before any next command
   endtask

   // One data transfer, then a quiet cycle so strobes never merge
   task automatic put(input logic [15:0] d);
      dat_o    <= d;
      dat_wr_o <= 1'b1;
      @(posedge clk_i);
      dat_wr_o <= 1'b0;
      dat_o    <= ~d;
      @(posedge clk_i);
   endtask

   // Pop one reply, keeping only the low byte
   task automatic pop(output logic [7:0] b, output bit ok);
      int n;
      n = 0;
      b = 8'hxx;
      while (rd_valid_i !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      ok = (rd_valid_i === 1'b1);
      if (ok) begin
         dat_rd_o <= 1'b1;
         @(posedge clk_i);
         b = rd_data_i[7:0];
         dat_rd_o <= 1'b0;
         @(posedge clk_i);
      end
   endtask
endmodule

// File: test/uecc_top_bench.sv
// Self-checking bench for the endpoint setup command decoder
`timescale 1ns/1ps
module uecc_top_bench;
   logic         mclk_i;
   logic         resetn_i;
   logic         bus16_i;
   logic         cmd_wr_i;
   logic [7:0]   cmd_code_i;
   logic         cmd_ready_o;
   logic         dat_wr_i;
   logic [15:0]  dat_i;
   logic         dat_rd_i;
   logic [15:0]  rd_data_o;
   logic         rd_valid_o;
   logic         usb_reset_i;
   logic [127:0] ep_status_i;
   logic [127:0] err_code_i;
   logic [15:0]  pkt_done_i;
   logic         ack_setup_o;
   logic         unlocked_o;
   logic         alloc_done_o;
   logic         fifo_invalidate_o;
   logic [15:0]  cfg_enable_o, cfg_dir_in_o, cfg_dbl_o, cfg_iso_o, buf_sel_o, alloc_bytes_o;
   int           miscompares = 0;   // Mismatches seen
   int           cmp_count   = 0;   // Comparisons made
   int           cyc         = 0;   // Cycle count for the hang guard
   int           acks        = 0;   // Setup acknowledge pulses
   int           invs        = 0;   // Invalidate pulses
   int           n0;                // Scratch count
   logic [7:0]   cfg [16];          // Expected setup byte per endpoint
   logic [15:0]  ev [4];            // Expected enable, direction, double, type
   logic [15:0]  sum;               // Expected allocation
   logic [7:0]   b;                 // Reply byte
   bit           ok;                // Handshake outcome

   uecc_top dut_u (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .bus16_i(bus16_i), .cmd_wr_i(cmd_wr_i),
      .cmd_code_i(cmd_code_i), .cmd_ready_o(cmd_ready_o), .dat_wr_i(dat_wr_i),
      .dat_i(dat_i), .dat_rd_i(dat_rd_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
      .usb_reset_i(usb_reset_i), .ep_status_i(ep_status_i), .err_code_i(err_code_i),
      .pkt_done_i(pkt_done_i), .ack_setup_o(ack_setup_o), .unlocked_o(unlocked_o),
      .cfg_enable_o(cfg_enable_o), .cfg_dir_in_o(cfg_dir_in_o), .cfg_dbl_o(cfg_dbl_o),
      .cfg_iso_o(cfg_iso_o), .buf_sel_o(buf_sel_o), .alloc_done_o(alloc_done_o),
      .alloc_bytes_o(alloc_bytes_o), .fifo_invalidate_o(fifo_invalidate_o));
   uecc_host host_u (
      .clk_i(mclk_i), .cmd_ready_i(cmd_ready_o), .rd_data_i(rd_data_o),
      .rd_valid_i(rd_valid_o), .cmd_wr_o(cmd_wr_i), .cmd_code_o(cmd_code_i),
      .dat_wr_o(dat_wr_i), .dat_o(dat_i), .dat_rd_o(dat_rd_i));

   // Clock, 8 ns period
   always #4 mclk_i = ~mclk_i;

   // Pulse counters and hang guard
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (ack_setup_o === 1'b1) acks <= acks + 1;
      if (fifo_invalidate_o === 1'b1) invs <= invs + 1;
      if (cyc == 20000) begin
         miscompares++;
         print_verdict();
      end
   end

   // Reference allocation for one setup byte
   function automatic logic [15:0] exp_alloc(input logic [7:0] c);
      logic [10:0] t [16];
      t = '{11'h008, 11'h010, 11'h020, 11'h040, 11'h080, 11'h100, 11'h180, 11'h200,
            11'h280, 11'h300, 11'h380, 11'h3FF, 11'h000, 11'h000, 11'h000, 11'h000};
      if (!c[7]) return 16'h0000;
      return c[5] ? {4'h0, t[c[3:0]], 1'b0} : {5'h00, t[c[3:0]]};
   endfunction

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask

   // Read command with its one-byte reply
   task automatic rd(input logic [7:0] c, output logic [7:0] r);
      host_u.cmd(c, ok);
      host_u.pop(r, ok);
   endtask

   // Setup write of one endpoint
   task automatic wr(input int i, input logic [7:0] v);
      host_u.cmd(8'h20 + 8'(i), ok);
      host_u.put({8'h00, v});
      repeat (3) @(posedge mclk_i);
   endtask

   // Unlock: one word on the wide bus, low then high byte on the narrow one
   task automatic ul(input logic w, input logic [15:0] d);
      bus16_i <= w;
      host_u.cmd(8'hB0, ok);
      host_u.put(w ? d : {8'h00, d[7:0]});
      if (!w) host_u.put({8'h00, d[15:8]});
      repeat (3) @(posedge mclk_i);
   endtask

   // Verdict and end of run
   task automatic print_verdict();
      if (miscompares == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Main sequence
   initial begin
      void'($urandom(87));
      mclk_i      = 1'b0;
      resetn_i    = 1'b0;
      bus16_i     = 1'b1;
      usb_reset_i = 1'b0;
      pkt_done_i  = 16'h0000;
      ep_status_i = {$urandom, $urandom, $urandom, $urandom};
      err_code_i  = {$urandom, $urandom, $urandom, $urandom};
      repeat (8) @(posedge mclk_i);
      resetn_i <= 1'b1;
      // Reset value of every setup register
      for (int i = 0; i < 16; i++) begin
         rd(8'h30 + 8'(i), b);
         check({8'h00, b}, 16'h0000, "setup reset value");
      end
      // Full in-order setup; control endpoints get fixed defaults
      sum = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         // Endpoint index 2 always double-buffered so the alternation check is exercised
         cfg[i] = (i < 2) ? {1'b1, i[0], 6'h03} : 8'($urandom) | ((i == 2) ? 8'h20 : 8'h00);
         sum = sum + exp_alloc(cfg[i]);
         for (int k = 0; k < 4; k++) ev[k][i] = cfg[i][7-k];
         if (i == 15) check({15'h0, alloc_done_o}, 16'h0000, "early allocation");
         wr(i, cfg[i]);
      end
      check({15'h0, alloc_done_o}, 16'h0001, "allocation done");
      check(alloc_bytes_o, sum, "allocated bytes");
      for (int i = 0; i < 16; i++) begin
         rd(8'h30 + 8'(i), b);
         check({8'h00, b}, {8'h00, cfg[i]}, "setup read back");
      end
      check(cfg_enable_o, ev[0], "enable bits");
      check(cfg_dir_in_o, ev[1], "direction bits");
      check(cfg_dbl_o, ev[2], "double bits");
      check(cfg_iso_o, ev[3], "type bits");
      // Packet completion swaps buffers of double-buffered endpoints only
      pkt_done_i <= 16'hFFFF;
      @(posedge mclk_i);
      pkt_done_i <= 16'h0000;
      repeat (3) @(posedge mclk_i);
      check(buf_sel_o, ev[2], "buffer select");
      // Type change keeps memory, enable change invalidates it
      n0 = invs;
      cfg[5] = cfg[5] ^ 8'h10;
      wr(5, cfg[5]);
      check(16'(invs - n0), 16'h0000, "no invalidate");
      cfg[5] = cfg[5] ^ 8'h80;
      wr(5, cfg[5]);
      check(16'(invs - n0), 16'h0001, "invalidate pulse");
      // Status image and error code reads
      for (int k = 0; k < 32; k++) begin
         rd((k < 16) ? 8'hD0 + 8'(k) : 8'h90 + 8'(k), b);
         if (k < 16) check({8'h00, b}, {8'h00, ep_status_i[8*k +: 8]}, "status");
         else check({8'h00, b}, {8'h00, err_code_i[8*k-128 +: 8]}, "error code");
      end
      // Acknowledge setup, no data bytes
      n0 = acks;
      host_u.cmd(8'hF4, ok);
      repeat (3) @(posedge mclk_i);
      check(16'(acks - n0), 16'h0001, "setup acknowledge");
      // Lock, refused write, then unlock in both bus widths
      ul(1'b1, 16'h1234);
      check({15'h0, unlocked_o}, 16'h0000, "locked");
      wr(3, ~cfg[3]);
      rd(8'h33, b);
      check({8'h00, b}, {8'h00, cfg[3]}, "write while locked");
      ul(1'b0, 16'hA5A5);
      check({15'h0, unlocked_o}, 16'h0001, "narrow unlock");
      ul(1'b1, 16'h5A5A);
      ul(1'b1, 16'hA5A5);
      check({15'h0, unlocked_o}, 16'h0001, "wide unlock, one word");
      // Fill the reply queue without popping, then drain it in order
      n0 = 0;
      ok = 1'b1;
      while (ok && n0 < 12) begin
         host_u.cmd(8'hD0 + 8'(n0), ok);
         if (ok) n0++;
      end
      check(16'(n0 >= 8), 16'h0001, "queue depth");
      for (int k = 0; k < n0; k++) begin
         host_u.pop(b, ok);
         check({8'h00, b}, {8'h00, ep_status_i[8*k +: 8]}, "queued reply");
      end
      repeat (4) @(posedge mclk_i);
      check({15'h0, rd_valid_o}, 16'h0000, "queue drained");
      // Bus reset disables all endpoints
      usb_reset_i <= 1'b1;
      @(posedge mclk_i);
      usb_reset_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      check(cfg_enable_o, 16'h0000, "bus reset");
      print_verdict();
   end
endmodule
